// ==== src/pfpt_top.sv ====
// Functional notes
// RULE1 - Byte-wide flash port with 19 address bits covers up to 512 KB.
// RULE2 - Both window bars are sized from the loaded flash size code.
// RULE3 - Flash address is masked to the window size so accesses wrap.
// RULE4 - Memory accesses hitting either window start a flash read or write.
// RULE5 - Host issues flash command sequences; bytes pass through uninterpreted.
// RULE6 - Wide accesses split into one flash byte per enabled lane.
// RULE7 - Host should avoid 32-bit accesses after initialization.
// RULE8 - Expansion ROM reads hold the bus with long wait states.
// RULE9 - Flash window reads in progress answer repeated attempts with retry.
// RULE10 - Write strobes only pulse when the write enable field allows it.
// RULE11 - Every window access ends its first data phase with STOP# asserted.
// RULE12 - Initiator uses single data phase transactions only.
// RULE13 - Reads keep TRDY# off until byte data valid, then drive AD.
// RULE14 - Initiator finishes a read data phase by asserting IRDY#.
// RULE15 - Initiator supplies address, command, enables and write data.
// RULE16 - Writes assert TRDY# only after data sits in the flash buffer.
// RULE17 - Flash strobes come from fixed internal cycle counts.
// RULE18 - Misses start no flash cycle; strobes stay idle during reset.
module pfpt_top
(
  input wire logic i_clk,
  input wire logic i_rst,
  input pfpt_pkg::pfpt_pci_in_t i_pci,
  input wire logic [31:0] i_flash_bar,
  input wire logic [31:0] i_erom_bar,
  input wire logic i_erom_en,
  input wire logic i_mem_en,
  input wire logic [1:0] i_flash_size,
  input wire logic [1:0] i_flash_write_enable_field,
  input wire logic [7:0] i_fl_din,
  output pfpt_pkg::pfpt_pci_out_t o_pci,
  output pfpt_pkg::pfpt_flash_out_t o_fl,
  output logic [31:0] o_bar_mask
);
  import pfpt_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  pfpt_state_t state_r;
  pfpt_state_t state_nxt;
  logic frame_q_r;
  logic hit_flash;
  logic hit_erom;
  logic [18:0] size_mask;
  logic [31:0] bar_mask;
  logic [1:0] size_r;
  logic addr_phase;
  logic cmd_rd;
  logic cmd_wr;
  logic hit;
  logic [18:0] req_off_r;
  logic req_wr_r;
  logic req_rom_r;
  logic [3:0] req_be;
  logic dr_match;
  logic eng_go;
  logic eng_go_delayed;
  logic eng_busy_r;
  logic eng_wr_r;
  logic eng_delayed_r;
  logic eng_wait_r;
  logic eng_fin_r;
  logic [3:0] eng_lanes_r;
  logic [1:0] eng_lane_r;
  logic [18:0] eng_off_r;
  logic [31:0] eng_data_r;
  logic dr_valid_r;
  logic [16:0] dr_word_r;
  logic [3:0] dr_be_r;
  logic cyc_start_r;
  logic cyc_busy;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic wr_allow;

  assign req_be = ~i_pci.cbe_n;
  assign cmd_rd = (i_pci.cbe_n == CMD_MEM_RD) || (i_pci.cbe_n == CMD_MEM_RD_MULT) || (i_pci.cbe_n == CMD_MEM_RD_LINE);
  assign cmd_wr = (i_pci.cbe_n == CMD_MEM_WR) || (i_pci.cbe_n == CMD_MEM_WR_INV);
  assign addr_phase = !i_pci.frame_n && frame_q_r && (state_r == ST_IDLE);
  assign hit = (hit_flash || hit_erom) && (cmd_rd || cmd_wr); // RULE18
  assign dr_match = dr_valid_r && (dr_word_r == req_off_r[18:2]) && (dr_be_r == req_be);
  assign wr_allow = (i_flash_write_enable_field == FWE_ENABLE); // RULE10

  // Lowest enabled lane goes first, keeping bytes in address order
  function automatic logic [1:0] first_lane(input logic [3:0] lanes);
    logic [1:0] sel;
    sel = 2'h3;
    for (int k = 3; k >= 0; k--)
    begin
      if (lanes[k])
      begin
        sel = 2'(k);
      end
    end
    return sel;
  endfunction : first_lane

  // ==========================================================
  // Window decode
  // ==========================================================
  pfpt_win_decode u_decode
  (
    .i_addr(i_pci.ad),
    .i_flash_bar(i_flash_bar),
    .i_erom_bar(i_erom_bar),
    .i_erom_en(i_erom_en),
    .i_mem_en(i_mem_en),
    .i_size(size_r),
    .o_hit_flash(hit_flash),
    .o_hit_erom(hit_erom),
    .o_size_mask(size_mask),
    .o_bar_mask(bar_mask)
  );

  // Size code is registered every cycle, so a change moves the window one cycle later, even mid-access
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      size_r <= SIZE_RST;
      o_bar_mask <= '0;
    end
    else
    begin
      size_r <= i_flash_size; // RULE2
      o_bar_mask <= bar_mask; // RULE2
    end
  end

  // Address phase capture
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      frame_q_r <= 1'b1;
      req_off_r <= '0;
      req_wr_r <= 1'b0;
      req_rom_r <= 1'b0;
    end
    else
    begin
      frame_q_r <= i_pci.frame_n;
      if (addr_phase && hit)
      begin
        req_off_r <= i_pci.ad[18:0] & size_mask; // RULE3
        req_wr_r <= cmd_wr;
        req_rom_r <= hit_erom && !hit_flash;
      end
    end
  end

  // ==========================================================
  // Target state machine
  // ==========================================================
  always_comb
  begin
    state_nxt = state_r;
    eng_go = 1'b0;
    eng_go_delayed = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (addr_phase && hit)
        begin
          state_nxt = ST_CLAIM; // RULE4
        end
      end
      ST_CLAIM:
      begin
        if (req_wr_r)
        begin
          state_nxt = eng_busy_r ? ST_RETRY : ST_WR_TAKE; // RULE9
        end
        else if (req_rom_r)
        begin
          // Shadowing path: hold with wait states, retrying only while the engine is still busy
          eng_go = !eng_busy_r; // RULE8
          state_nxt = eng_busy_r ? ST_RETRY : ST_RD_WAIT;
        end
        else if (dr_match)
        begin
          state_nxt = ST_DATA; // RULE13
        end
        else
        begin
          eng_go = !eng_busy_r && !eng_fin_r; // Finishing fetch still busy, so its result is kept
          eng_go_delayed = 1'b1;
          state_nxt = ST_RETRY; // RULE9
        end
      end
      ST_WR_TAKE:
      begin
        if (!i_pci.irdy_n)
        begin
          eng_go = 1'b1; // RULE16
          state_nxt = ST_DATA;
        end
      end
      ST_RD_WAIT:
      begin
        if (eng_fin_r)
        begin
          state_nxt = ST_DATA; // RULE13
        end
      end
      ST_DATA, ST_RETRY:
      begin
        if (!i_pci.irdy_n)
        begin
          state_nxt = ST_TURN; // RULE14
        end
      end
      ST_TURN:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Bus pins follow the next state so they line up with state_r
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pci <= '{ad: '0, ad_oe: 1'b0, devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, ctl_oe: 1'b0};
    end
    else
    begin
      o_pci.devsel_n <= (state_nxt == ST_IDLE) || (state_nxt == ST_TURN);
      o_pci.trdy_n <= (state_nxt != ST_DATA); // RULE13
      o_pci.stop_n <= !((state_nxt == ST_DATA) || (state_nxt == ST_RETRY)); // RULE11
      o_pci.ctl_oe <= (state_nxt != ST_IDLE);
      o_pci.ad_oe <= !req_wr_r && (state_nxt != ST_IDLE) && (state_nxt != ST_CLAIM) && (state_nxt != ST_TURN);
      if (state_nxt == ST_DATA && !req_wr_r)
      begin
        o_pci.ad <= eng_data_r; // RULE13
      end
    end
  end

  // ==========================================================
  // Byte engine: splits a word access into flash byte cycles
  // ==========================================================
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      eng_busy_r <= 1'b0;
      eng_wr_r <= 1'b0;
      eng_delayed_r <= 1'b0;
      eng_wait_r <= 1'b0;
      eng_fin_r <= 1'b0;
      eng_lanes_r <= '0;
      eng_lane_r <= '0;
      eng_off_r <= '0;
      eng_data_r <= '0;
      cyc_start_r <= 1'b0;
    end
    else
    begin
      eng_fin_r <= 1'b0;
      cyc_start_r <= 1'b0;
      if (eng_go)
      begin
        eng_busy_r <= 1'b1;
        eng_wr_r <= req_wr_r;
        eng_delayed_r <= eng_go_delayed;
        eng_lanes_r <= req_be; // RULE6
        eng_off_r <= {req_off_r[18:2], 2'h0};
        eng_data_r <= req_wr_r ? i_pci.ad : 32'h0000_0000; // RULE16
      end
      else if (eng_busy_r && !eng_wait_r)
      begin
        if (eng_lanes_r == 4'h0)
        begin
          eng_busy_r <= 1'b0;
          eng_fin_r <= 1'b1;
        end
        else
        begin
          eng_lane_r <= first_lane(eng_lanes_r); // RULE6
          eng_lanes_r[first_lane(eng_lanes_r)] <= 1'b0;
          eng_wait_r <= 1'b1;
          cyc_start_r <= 1'b1;
        end
      end
      else if (cyc_done)
      begin
        eng_wait_r <= 1'b0;
        if (!eng_wr_r)
        begin
          eng_data_r[8 * eng_lane_r +: 8] <= cyc_rdata; // RULE6
        end
      end
    end
  end

  // Delayed read result; fresh data wins over a same-cycle consume
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dr_valid_r <= 1'b0;
      dr_word_r <= '0;
      dr_be_r <= '0;
    end
    else
    begin
      if (eng_go)
      begin
        dr_valid_r <= 1'b0;
        dr_word_r <= req_off_r[18:2];
        dr_be_r <= req_be;
      end
      else if (eng_fin_r && eng_delayed_r && !eng_wr_r)
      begin
        dr_valid_r <= 1'b1; // RULE9
      end
      else if (state_r == ST_CLAIM && !req_wr_r && !req_rom_r && dr_match)
      begin
        dr_valid_r <= 1'b0;
      end
    end
  end

  // Host command sequences are just bytes here; nothing is decoded
  pfpt_flash_cycle u_cycle
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(cyc_start_r),
    .i_write(eng_wr_r),
    .i_wr_allow(wr_allow),
    .i_addr(eng_off_r | {17'h0_0000, eng_lane_r}), // RULE1
    .i_wdata(eng_data_r[8 * eng_lane_r +: 8]), // RULE5
    .i_fl_din(i_fl_din),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_fl(o_fl)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_retry;
    !o_pci.stop_n && o_pci.trdy_n && !o_pci.devsel_n;
  endsequence

  sequence s_disconnect;
    !o_pci.stop_n && !o_pci.trdy_n;
  endsequence

  AST_TRDY_WITH_STOP: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
    !o_pci.trdy_n |-> s_disconnect)
    else $error("TRDY# without STOP#");

  AST_RETRY_SHAPE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
    (state_r == ST_RETRY) |-> s_retry)
    else $error("retry shape wrong");

  AST_MISS_NO_CLAIM: assert property (@(posedge i_clk) disable iff (i_rst) // RULE18
    (addr_phase && !hit) |=> (o_pci.devsel_n && !eng_go) [*2])
    else $error("miss was claimed");

  AST_HIT_CLAIM: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
    (addr_phase && hit) |=> !o_pci.devsel_n && o_pci.trdy_n)
    else $error("hit not claimed");

  AST_WR_TAKEN_FIRST: assert property (@(posedge i_clk) disable iff (i_rst) // RULE16
    ($fell(o_pci.trdy_n) && req_wr_r) |-> (eng_busy_r && eng_wr_r))
    else $error("write TRDY# before buffer load");

  AST_RD_DATA_VALID: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
    ($fell(o_pci.trdy_n) && !req_wr_r) |-> (o_pci.ad == eng_data_r) && o_pci.ad_oe && !eng_busy_r)
    else $error("read data not valid at TRDY#");

  AST_ROM_WAITS: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
    (state_r == ST_RD_WAIT) |-> o_pci.trdy_n && o_pci.stop_n && !o_pci.devsel_n)
    else $error("ROM wait state broken");

  AST_ADDR_WRAP: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
    !o_fl.ce_n |-> ((o_fl.addr & ~size_mask) == 19'h0_0000))
    else $error("flash address beyond window");

  AST_WE_GATED: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
    !o_fl.we_n |-> $past(wr_allow))
    else $error("write strobe while disabled");

  AST_ONE_BYTE_AT_A_TIME: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
    cyc_start_r |-> !cyc_busy ##1 cyc_busy)
    else $error("byte cycles overlap");

endmodule : pfpt_top

// ==== src/pfpt_pkg.sv ====
package pfpt_pkg;

  // ==========================================================
  // Configuration space placement of the two windows
  // ==========================================================
  localparam logic [7:0] CFG_FLASH_BAR_OFS = 8'h14;
  localparam logic [7:0] CFG_FLASH_BAR_ALT_OFS = 8'h18;
  localparam logic [7:0] CFG_EROM_BAR_OFS = 8'h30;

  // ==========================================================
  // Flash geometry
  // ==========================================================
  localparam int FL_ADDR_W = 19;
  localparam logic [31:0] WIN_MIN_BYTES = 32'h0001_0000;
  localparam logic [1:0] SIZE_RST = 2'h0;

  // Write enable field encodings
  localparam logic [1:0] FWE_DISABLE = 2'h1;
  localparam logic [1:0] FWE_ENABLE = 2'h2;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int FL_RD_TIME_NS = 256;
  localparam int FL_WE_TIME_NS = 100;
  localparam int FL_RD_CYC = (FL_RD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FL_WE_CYC = (FL_WE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FL_CNT_W = 5;

  // ==========================================================
  // Bus commands
  // ==========================================================
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } pfpt_pci_in_t;

  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic ctl_oe;
  } pfpt_pci_out_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dout;
    logic dout_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } pfpt_flash_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLAIM = 3'b001,
    ST_WR_TAKE = 3'b010,
    ST_RD_WAIT = 3'b011,
    ST_DATA = 3'b100,
    ST_RETRY = 3'b101,
    ST_TURN = 3'b110
  } pfpt_state_t;

endpackage : pfpt_pkg

// ==== src/pfpt_win_decode.sv ====
module pfpt_win_decode
(
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_flash_bar,
  input wire logic [31:0] i_erom_bar,
  input wire logic i_erom_en,
  input wire logic i_mem_en,
  input wire logic [1:0] i_size,
  output logic o_hit_flash,
  output logic o_hit_erom,
  output logic [18:0] o_size_mask,
  output logic [31:0] o_bar_mask
);
  import pfpt_pkg::*;

  // ==========================================================
  // Window size from the stored size code
  // ==========================================================
  logic [31:0] win_bytes;
  logic [31:0] win_mask;

  // Both windows share one size, so one mask serves both bars
  always_comb
  begin
    win_bytes = WIN_MIN_BYTES << i_size; // RULE2
    win_mask = ~(win_bytes - 32'h0000_0001);
    o_bar_mask = win_mask; // RULE2
    o_size_mask = ~win_mask[18:0];
    o_hit_flash = i_mem_en && ((i_addr & win_mask) == (i_flash_bar & win_mask)); // RULE4
    o_hit_erom = i_mem_en && i_erom_en && ((i_addr & win_mask) == (i_erom_bar & win_mask)); // RULE4
  end

endmodule : pfpt_win_decode

// ==== src/pfpt_flash_cycle.sv ====
module pfpt_flash_cycle
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_wr_allow,
  input wire logic [18:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_fl_din,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output pfpt_pkg::pfpt_flash_out_t o_fl
);
  import pfpt_pkg::*;

  localparam logic [FL_CNT_W-1:0] RD_LAST = FL_CNT_W'(FL_RD_CYC);
  localparam logic [FL_CNT_W-1:0] WE_LAST = FL_CNT_W'(FL_WE_CYC);
  localparam int RD_CYC_A = FL_RD_CYC;

  logic [FL_CNT_W-1:0] cnt_r;
  logic wr_r;
  logic [FL_CNT_W-1:0] strobe_last;

  assign strobe_last = wr_r ? WE_LAST : RD_LAST;

  // ==========================================================
  // One byte cycle: setup, strobe, hold
  // ==========================================================
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      cnt_r <= '0;
      wr_r <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_busy)
      begin
        o_busy <= 1'b1;
        cnt_r <= '0;
        wr_r <= i_write;
      end
      else if (o_busy)
      begin
        if (cnt_r == strobe_last + 1'b1)
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Strobe pins; a refused write still runs its count so timing stays fixed
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_fl <= '{addr: '0, dout: '0, dout_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1}; // RULE18
      o_rdata <= '0;
    end
    else if (i_start && !o_busy)
    begin
      o_fl.addr <= i_addr;
      o_fl.dout <= i_wdata;
      o_fl.dout_oe <= i_write && i_wr_allow; // RULE10
    end
    else if (o_busy)
    begin
      if (cnt_r == '0)
      begin
        o_fl.ce_n <= wr_r && !i_wr_allow; // RULE17
        o_fl.oe_n <= wr_r; // RULE17
        o_fl.we_n <= !(wr_r && i_wr_allow); // RULE10
      end
      else if (cnt_r == strobe_last)
      begin
        o_fl.ce_n <= 1'b1;
        o_fl.oe_n <= 1'b1;
        o_fl.we_n <= 1'b1;
        if (!wr_r)
        begin
          o_rdata <= i_fl_din;
        end
      end
      else if (cnt_r == strobe_last + 1'b1)
      begin
        o_fl.dout_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  AST_RD_STROBE_LEN: assert property (@(posedge i_clk) disable iff (i_rst) // RULE17
    $fell(o_fl.oe_n) |-> ##RD_CYC_A $rose(o_fl.oe_n))
    else $error("read strobe length wrong");

  AST_STROBES_IN_RESET: assert property (@(posedge i_clk) // RULE18
    $past(i_rst) |-> (o_fl.ce_n && o_fl.oe_n && o_fl.we_n))
    else $error("flash strobe active after reset");

endmodule : pfpt_flash_cycle

// ==== dv/pfpt_pci_init.sv ====
module pfpt_pci_init
(
  input wire logic i_clk,
  input pfpt_pkg::pfpt_pci_out_t i_pci,
  output pfpt_pkg::pfpt_pci_in_t o_pci
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfpt_pkg::*;

  // ==========================================================
  // Single data phase bus initiator
  // ==========================================================
  initial o_pci = '{1'b1, 1'b1, 4'hF, 32'h0};

  // Codes: 0 done, 1 retry, 3 never claimed, 4 TRDY# without STOP#
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be_n,
    input logic [31:0] wdata, output logic [31:0] rdata, output int code, output int cyc);
    begin
      code = 3;
      rdata = 32'h0;
      repeat (2) @(posedge i_clk);
      o_pci <= '{1'b0, 1'b1, cmd, addr};
      @(posedge i_clk);
      // FRAME# leaves with IRDY# on, so only one data phase exists
      o_pci <= '{1'b1, 1'b0, be_n, wdata};
      for (cyc = 0; cyc < 2000; cyc++)
      begin
        @(posedge i_clk);
        // Control pins only count while driven; undriven AD reads back inverted
        if (i_pci.ctl_oe === 1'b1 && (i_pci.stop_n === 1'b0 || i_pci.trdy_n === 1'b0))
        begin
          code = (i_pci.trdy_n === 1'b0) ? ((i_pci.stop_n === 1'b0) ? 0 : 4) : 1;
          rdata = (i_pci.ad_oe === 1'b1) ? i_pci.ad : ~i_pci.ad;
          break;
        end
        if (cyc == 5 && i_pci.devsel_n !== 1'b0)
          break;
      end
      // Released AD shows inverted data, never a stale copy
      o_pci <= '{1'b1, 1'b1, 4'hF, ~wdata};
    end
  endtask : xfer
endmodule : pfpt_pci_init

// ==== dv/test_parallel_flash_pci_target.sv ====
module test_parallel_flash_pci_target;
  timeunit 1ns;
  timeprecision 1ns;
  import pfpt_pkg::*;

  logic clk;
  logic rst;
  pfpt_pci_in_t pci_in;
  pfpt_pci_out_t pci_out;
  pfpt_flash_out_t fl;
  logic [31:0] flash_bar, erom_bar, bar_mask, rd;
  logic erom_en, mem_en, oe_q, we_q, wr_oe;
  logic [1:0] size, flash_write_enable_field;
  logic [7:0] fl_din, wr_data;
  logic [18:0] wr_addr;
  int errors, num_checks, rd_cnt, wr_cnt, oe_len, we_len, run_len, code, cyc;

  // ==========================================================
  // Design, host and flash part
  // ==========================================================
  pfpt_top i_dut
  (
    .i_clk(clk), .i_rst(rst), .i_pci(pci_in), .i_flash_bar(flash_bar), .i_erom_bar(erom_bar),
    .i_erom_en(erom_en), .i_mem_en(mem_en), .i_flash_size(size), .i_flash_write_enable_field(flash_write_enable_field),
    .i_fl_din(fl_din), .o_pci(pci_out), .o_fl(fl), .o_bar_mask(bar_mask)
  );

  pfpt_pci_init i_host(.i_clk(clk), .i_pci(pci_out), .o_pci(pci_in));

  function automatic logic [7:0] fmem(input logic [18:0] a);
    return 8'h3C ^ a[7:0] ^ {5'h00, a[18:16]};
  endfunction : fmem

  // Unselected part shows inverted bytes so a stale read never matches
  assign fl_din = fmem(fl.addr) ^ {8{fl.ce_n | fl.oe_n}};

  // Strobe monitor: counts cycles and pulse lengths
  always @(posedge clk)
  begin
    if (fl.oe_n === 1'b0 && oe_q === 1'b1)
      rd_cnt++;
    if (fl.oe_n === 1'b1 && oe_q === 1'b0)
      oe_len = run_len;
    if (fl.we_n === 1'b1 && we_q === 1'b0)
    begin
      wr_cnt++;
      we_len = run_len;
    end
    if (fl.we_n === 1'b0)
    begin
      wr_addr = fl.addr;
      wr_data = fl.dout;
      wr_oe = fl.dout_oe;
    end
    run_len = (fl.oe_n === 1'b0 || fl.we_n === 1'b0) ? run_len + 1 : 0;
    oe_q = fl.oe_n;
    we_q = fl.we_n;
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        errors++;
        $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
      end
    end
  endtask : check

  // Retries as a well behaved host would, up to a bound
  task automatic go(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be_n,
    input logic [31:0] wdata);
    begin
      code = 1;
      for (int i = 0; i < 30 && code == 1; i++)
        i_host.xfer(cmd, addr, be_n, wdata, rd, code, cyc);
    end
  endtask : go

  task automatic complete_run();
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask : complete_run

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_sizes();
    begin
      for (int s = 0; s < 4; s++)
      begin
        size <= s[1:0];
        repeat (3) @(posedge clk);
        check(bar_mask, ~((WIN_MIN_BYTES << s) - 32'h1), "bar mask");
      end
    end
  endtask : t_sizes

  // Shadowing reads whole dwords through the ROM window with each read command
  task automatic t_rom_read();
    logic [3:0] cmds [3];
    int n0;
    logic [18:0] a;
    begin
      cmds = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
      for (int k = 0; k < 3; k++)
      begin
        n0 = rd_cnt;
        a = 19'h100 + 19'(16 * k);
        go(cmds[k], 32'h9000_0000 + 32'(a), 4'h0, 32'h0);
        check(code, 0, "rom read end");
        check(rd, {fmem(a + 19'h3), fmem(a + 19'h2), fmem(a + 19'h1), fmem(a)}, "rom data");
        check(rd_cnt - n0, 4, "bytes per dword");
        check(cyc > 25, 1, "long wait states");
        check(oe_len, FL_RD_CYC, "read strobe length");
      end
    end
  endtask : t_rom_read

  task automatic t_fl_read();
    int n0;
    begin
      n0 = rd_cnt;
      i_host.xfer(CMD_MEM_RD, 32'h8000_0040, 4'hD, 32'h0, rd, code, cyc);
      check(code, 1, "first attempt retried");
      go(CMD_MEM_RD, 32'h8000_0040, 4'hD, 32'h0);
      check(code, 0, "delayed read end");
      check(rd[15:8], fmem(19'h41), "lane one data");
      check(rd_cnt - n0, 1, "one byte fetched");
    end
  endtask : t_fl_read

  // Small part: upper offset bits must not reach the flash
  task automatic t_wrap();
    begin
      size <= 2'h0;
      erom_bar <= 32'h9003_0000;
      repeat (3) @(posedge clk);
      go(CMD_MEM_RD, 32'h9003_0004, 4'hE, 32'h0);
      check(rd[7:0], fmem(19'h4), "wrapped byte");
      size <= 2'h3;
      erom_bar <= 32'h9000_0000;
    end
  endtask : t_wrap

  task automatic t_write();
    int n0;
    begin
      flash_write_enable_field <= FWE_ENABLE;
      n0 = wr_cnt;
      // Command bytes of the part pass through untouched
      go(CMD_MEM_WR, 32'h8000_0020, 4'hB, 32'h11A5_3344);
      check(code, 0, "write end");
      for (int i = 0; i < 100 && wr_cnt == n0; i++)
        @(posedge clk);
      check(wr_cnt - n0, 1, "one write strobe");
      check(wr_addr, 19'h22, "write address");
      check(wr_data, 8'hA5, "write lane");
      check(wr_oe, 1, "write data driven");
      check(we_len, FL_WE_CYC, "write strobe length");
      flash_write_enable_field <= FWE_DISABLE;
      n0 = wr_cnt;
      go(CMD_MEM_WR_INV, 32'h8000_0024, 4'hE, 32'h0000_0077);
      check(code, 0, "blocked write end");
      repeat (60) @(posedge clk);
      check(wr_cnt - n0, 0, "blocked strobe");
    end
  endtask : t_write

  task automatic t_miss();
    int n0;
    begin
      n0 = rd_cnt;
      go(CMD_MEM_RD, 32'h4000_0000, 4'h0, 32'h0);
      check(code, 3, "outside windows");
      mem_en <= 1'b0;
      go(CMD_MEM_RD, 32'h8000_0000, 4'h0, 32'h0);
      check(code, 3, "memory space off");
      mem_en <= 1'b1;
      erom_en <= 1'b0;
      go(CMD_MEM_RD, 32'h9000_0000, 4'h0, 32'h0);
      check(code, 3, "rom decode off");
      erom_en <= 1'b1;
      check(rd_cnt - n0, 0, "no flash cycle");
    end
  endtask : t_miss

  // ==========================================================
  // Clock, sequence and watchdog
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    flash_bar = 32'h8000_0000;
    erom_bar = 32'h9000_0000;
    erom_en = 1'b1;
    mem_en = 1'b1;
    size = 2'h3;
    flash_write_enable_field = FWE_DISABLE;
    oe_q = 1'b1;
    we_q = 1'b1;
    repeat (8) @(posedge clk);
    check(fl.ce_n, 1, "reset chip select");
    check(fl.we_n, 1, "reset write strobe");
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_sizes();
    t_rom_read();
    t_fl_read();
    t_wrap();
    t_write();
    t_miss();
    complete_run();
  end

  // Whole run needs under 3000 cycles
  initial
  begin
    repeat (8000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : test_parallel_flash_pci_target
